// [rtl/ciwt_counter.sv]
// Loadable down counter holding the live count
`timescale 1ns/10ps
module ciwt_counter #(
   parameter int W = 32,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clock, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic load, // Load takes priority over decrement
   input wire logic [W-1:0] load_val, // Value to load
   input wire logic dec, // Decrement by one
   output logic [W-1:0] count_r, // Live count
   output logic at_zero // Count is zero
);

   logic [W-1:0] count_nxt;

   assign count_nxt = load ? load_val : (dec ? count_r - 1'b1 : count_r);
   assign at_zero = (count_r == '0);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_r <= INIT;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule

// [rtl/ciwt_pkg.sv]
// Shared constants and types for the configurable interval watchdog timer
package ciwt_pkg;

   localparam int HALF_W = 16;
   localparam int WORD_W = 32;
   localparam int CTL_W = 4;
   localparam int OPT_W = 5;

   typedef logic [HALF_W-1:0] ciwt_half_t;
   typedef logic [WORD_W-1:0] ciwt_word_t;
   typedef logic [CTL_W-1:0] ciwt_ctl_t;
   typedef logic [OPT_W-1:0] ciwt_opt_t;

   // Build option bit positions
   localparam int OPT_WR_PERIOD = 0;
   localparam int OPT_SNAPSHOT = 1;
   localparam int OPT_START_STOP = 2;
   localparam int OPT_PULSE = 3;
   localparam int OPT_WATCHDOG = 4;

   // Preset configurations
   localparam ciwt_opt_t CIWT_PRESET_SIMPLE = 5'h00;
   localparam ciwt_opt_t CIWT_PRESET_FULL = 5'h0f;
   localparam ciwt_opt_t CIWT_PRESET_WATCHDOG = 5'h10;

   // Control word fields
   localparam int CTL_IRQ_EN = 0;
   localparam int CTL_REPEAT = 1;
   localparam int CTL_START = 2;
   localparam int CTL_STOP = 3;

   // Status word fields
   localparam int STAT_EXPIRED = 0;

   // Default timeout period
   localparam int CLK_MHZ = 100;
   localparam int TIMEOUT_PERIOD_US = 1000;
   localparam int TIMEOUT_CYCLES = TIMEOUT_PERIOD_US * CLK_MHZ;
   localparam ciwt_word_t TIMEOUT_RELOAD = WORD_W'(TIMEOUT_CYCLES - 1);

   localparam ciwt_word_t WORD_ZERO = 32'h0000_0000;
   localparam ciwt_half_t HALF_ZERO = 16'h0000;

endpackage

// [rtl/ciwt_timer.sv]
// Configurable interval watchdog timer, top level
`timescale 1ns/10ps
module ciwt_timer
   import ciwt_pkg::*;
#(
   parameter ciwt_pkg::ciwt_opt_t OPTIONS = ciwt_pkg::CIWT_PRESET_FULL,
   parameter ciwt_pkg::ciwt_word_t DEFAULT_PERIOD = ciwt_pkg::TIMEOUT_RELOAD
) (
   input wire logic clock, // System clock, 100 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic period_lo_wr, // Write strobe, low period half
   input wire logic period_hi_wr, // Write strobe, high period half
   input wire ciwt_pkg::ciwt_half_t period_wdata, // Period half data
   input wire logic snap_req, // Capture count strobe
   input wire logic ctrl_wr, // Control write strobe
   input wire ciwt_pkg::ciwt_ctl_t ctrl_wdata, // Control write data
   input wire logic status_wr, // Status write strobe
   input wire ciwt_pkg::ciwt_half_t status_wdata, // Status write data
   output ciwt_pkg::ciwt_word_t period_q, // Period, period minus one
   output ciwt_pkg::ciwt_word_t snap_q, // Captured count
   output logic expired_flag, // Sticky timeout flag
   output logic running, // Counter is running
   output logic irq_enable_bit, // Interrupt enable
   output logic repeat_mode_bit, // Continuous count mode
   output logic irq, // Interrupt request, level
   output logic timeout_pulse, // One clock at each zero
   output logic reset_request // One clock at watchdog zero
);

   import ciwt_pkg::*;

   // Build option decode
   localparam bit HAS_WR = OPTIONS[OPT_WR_PERIOD];
   localparam bit HAS_SNAP = OPTIONS[OPT_SNAPSHOT];
   localparam bit HAS_SS = OPTIONS[OPT_START_STOP];
   localparam bit HAS_PULSE = OPTIONS[OPT_PULSE];
   localparam bit HAS_WD = OPTIONS[OPT_WATCHDOG];
   // Without start/stop or watchdog nothing may ever halt the count
   localparam bit FREE_RUN = !HAS_SS && !HAS_WD;
   localparam bit RUN_INIT = FREE_RUN;

   ciwt_word_t period_r, period_nxt, period_merge;
   ciwt_word_t snap_r, snap_nxt;
   ciwt_word_t count;
   logic at_zero;
   logic running_r, running_nxt;
   logic expired_r, expired_nxt;
   logic irq_en_r, irq_en_nxt;
   logic repeat_r, repeat_nxt;
   logic irq_r, irq_nxt;
   logic pulse_r, pulse_nxt;
   logic rst_req_r, rst_req_nxt;
   logic [1:0] half_wr;
   logic period_wr, kick, zero_hit, repeat_eff;
   logic start_wr, stop_wr, flag_clr, cnt_load, cnt_dec;

   // Write decode
   assign half_wr = {period_hi_wr, period_lo_wr};
   assign period_wr = period_lo_wr || period_hi_wr;
   // Start exists whenever the watchdog does
   assign start_wr = ctrl_wr && ctrl_wdata[CTL_START]
                     && (HAS_SS || HAS_WD);
   // Stop is dead in a watchdog: it can never halt a started counter
   assign stop_wr = ctrl_wr && ctrl_wdata[CTL_STOP]
                    && HAS_SS && !HAS_WD;
   assign flag_clr = status_wr && !status_wdata[STAT_EXPIRED];

   // Period halves
   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_half
         assign period_merge[h*HALF_W +: HALF_W] =
            half_wr[h] ? period_wdata : period_r[h*HALF_W +: HALF_W];
      end
   endgenerate

   // Watchdog ignores the data; writes only kick
   assign period_nxt = (HAS_WR && !HAS_WD && period_wr)
                       ? period_merge : period_r;
   assign kick = period_wr && (HAS_WR || HAS_WD);

   // Counting
   assign zero_hit = running_r && at_zero;
   // Watchdog and free-run builds never stop themselves at zero
   assign repeat_eff = repeat_r || FREE_RUN || HAS_WD;
   assign cnt_load = zero_hit || kick;
   assign cnt_dec = running_r && !at_zero;

   assign running_nxt = FREE_RUN ? 1'b1
                      : stop_wr ? 1'b0
                      : start_wr ? 1'b1
                      : (zero_hit && !repeat_eff) ? 1'b0
                      : running_r;

   // Set wins over a clear in the same cycle
   assign expired_nxt = zero_hit || (expired_r && !flag_clr);
   assign irq_en_nxt = ctrl_wr ? ctrl_wdata[CTL_IRQ_EN] : irq_en_r;
   assign repeat_nxt = ctrl_wr ? ctrl_wdata[CTL_REPEAT] : repeat_r;
   assign irq_nxt = expired_nxt && irq_en_nxt;
   assign pulse_nxt = zero_hit && HAS_PULSE;
   assign rst_req_nxt = zero_hit && HAS_WD;
   assign snap_nxt = (HAS_SNAP && snap_req) ? count : snap_r;

   ciwt_counter #(
      .W(WORD_W),
      .INIT(DEFAULT_PERIOD)
   ) u_counter (
      .clock(clock),
      .rstn(rstn),
      .load(cnt_load),
      .load_val(period_nxt),
      .dec(cnt_dec),
      .count_r(count),
      .at_zero(at_zero)
   );

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         period_r <= DEFAULT_PERIOD;
         snap_r <= WORD_ZERO;
      end else begin
         period_r <= period_nxt;
         snap_r <= snap_nxt;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         running_r <= RUN_INIT;
         expired_r <= 1'b0;
         irq_en_r <= 1'b0;
         repeat_r <= 1'b0;
      end else begin
         running_r <= running_nxt;
         expired_r <= expired_nxt;
         irq_en_r <= irq_en_nxt;
         repeat_r <= repeat_nxt;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
         pulse_r <= 1'b0;
         rst_req_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
         pulse_r <= pulse_nxt;
         rst_req_r <= rst_req_nxt;
      end
   end

   assign period_q = period_r;
   assign snap_q = snap_r;
   assign expired_flag = expired_r;
   assign running = running_r;
   assign irq_enable_bit = irq_en_r;
   assign repeat_mode_bit = repeat_r;
   assign irq = irq_r;
   assign timeout_pulse = pulse_r;
   assign reset_request = rst_req_r;

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   fixed_period_a: assert property (
      !HAS_WR |-> period_q == DEFAULT_PERIOD)
      else $error("fixed period changed");

   period_write_a: assert property (
      HAS_WR && !HAS_WD && period_lo_wr && !period_hi_wr
      |=> period_q[HALF_W-1:0] == $past(period_wdata)
          && count == period_q)
      else $error("low period write not taken");

   snap_capture_a: assert property (
      HAS_SNAP && snap_req |=> snap_q == $past(count))
      else $error("snapshot not captured");

   no_snap_a: assert property (
      !HAS_SNAP |-> snap_q == WORD_ZERO)
      else $error("snapshot present without option");

   free_run_a: assert property (
      FREE_RUN |-> running)
      else $error("free running counter halted");

   stop_halts_a: assert property (
      HAS_SS && !HAS_WD && ctrl_wr && ctrl_wdata[CTL_STOP]
      |=> !running ##1 !running || $past(start_wr))
      else $error("stop did not halt counter");

   wdog_boot_a: assert property (
      HAS_WD && !running && !start_wr |=> !running)
      else $error("watchdog started without start bit");

   wdog_start_a: assert property (
      HAS_WD && ctrl_wr && ctrl_wdata[CTL_START] |=> running)
      else $error("watchdog start bit ignored");

   wdog_hold_a: assert property (
      HAS_WD && running |=> running [*4])
      else $error("watchdog counter halted");

   kick_reload_a: assert property (
      HAS_WD && period_wr |=> count == DEFAULT_PERIOD
                               && period_q == DEFAULT_PERIOD)
      else $error("kick did not reload fixed period");

   count_step_a: assert property (
      running && !at_zero && !kick |=> count == $past(count) - 1'b1)
      else $error("counter did not decrement");

   zero_reload_a: assert property (
      zero_hit && !kick |=> count == period_q)
      else $error("no reload at zero");

   zero_events_a: assert property (
      zero_hit |=> expired_flag
                   && timeout_pulse == HAS_PULSE
                   && reset_request == HAS_WD)
      else $error("zero events not in reload cycle");

   pulse_cause_a: assert property (
      timeout_pulse |-> HAS_PULSE && $past(zero_hit))
      else $error("timeout pulse without zero");

   rstreq_cause_a: assert property (
      reset_request |-> HAS_WD && $past(zero_hit))
      else $error("reset request without zero");

   flag_sticky_a: assert property (
      expired_flag && !flag_clr |=> expired_flag)
      else $error("expired flag dropped");

   flag_clear_a: assert property (
      flag_clr && !zero_hit |=> !expired_flag)
      else $error("expired flag not cleared");

   irq_gate_a: assert property (
      ##1 irq == (expired_flag && irq_enable_bit))
      else $error("interrupt not gated by enable");

   oneshot_stop_a: assert property (
      zero_hit && !repeat_eff && !start_wr |=> !running)
      else $error("one shot counter kept running");

   repeat_run_a: assert property (
      zero_hit && repeat_eff && !stop_wr |=> running)
      else $error("repeat counter stopped at zero");

   start_run_a: assert property (
      HAS_SS && !HAS_WD && start_wr && !stop_wr |=> running)
      else $error("start did not run counter");

   halted_hold_a: assert property (
      !running && !kick |=> count == $past(count))
      else $error("halted counter moved");

   snap_hold_a: assert property (
      !snap_req |=> snap_q == $past(snap_q))
      else $error("snapshot changed without request");

   // Pulses are one clock wide unless the period is zero
   pulse_width_a: assert property (
      timeout_pulse && period_q != WORD_ZERO |=> !timeout_pulse)
      else $error("timeout pulse too wide");

   rstreq_width_a: assert property (
      reset_request && period_q != WORD_ZERO |=> !reset_request)
      else $error("reset request too wide");

   irq_mask_a: assert property (
      !irq_enable_bit |-> !irq)
      else $error("interrupt raised while disabled");

   zero_seen_c: cover property (zero_hit ##1 expired_flag);
   oneshot_seen_c: cover property (zero_hit && !repeat_eff ##1 !running);
   kick_seen_c: cover property (HAS_WD && running && kick);
   clear_seen_c: cover property (expired_flag ##1 flag_clr ##1 !irq);
   stop_seen_c: cover property (running ##1 stop_wr ##1 !running);

endmodule

// [tb/ciwt_host.sv]
// Processor-side model driving the timer's write and capture strobes
`timescale 1ns/10ps
module ciwt_host (
   input wire logic clock, // System clock
   output logic [4:0] stb, // lo, hi, ctrl, status, snap strobes
   output logic [15:0] wdata // Shared write data
);
   initial begin
      stb = 5'h00;
      wdata = 16'h0000;
   end

   // One write: raise on an edge, taken and released at the next edge
   task automatic put(input logic [4:0] s, input logic [15:0] d);
      @(posedge clock);
      stb <= s;
      wdata <= d;
      @(posedge clock);
      stb <= 5'h00;
      // Released data must not keep looking valid
      wdata <= ~d;
   endtask

   // Watchdog kick, spaced well inside the timeout
   task automatic kick();
      put(5'h01, 16'h0005);
      repeat (6) @(posedge clock);
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the full, watchdog and simple builds of the timer
`timescale 1ns/10ps
module testbench;
   import ciwt_pkg::*;
   logic clock;
   logic rstn;
   logic [4:0] stb;
   logic [15:0] wdata;
   ciwt_word_t f_pq, f_sq, w_pq, w_sq;
   logic f_exp, f_run, f_ie, f_rm, f_irq, f_tp, f_rr;
   logic w_exp, w_run, w_ie, w_rm, w_irq, w_tp, w_rr;
   ciwt_word_t s_pq;
   logic s_run, s_irq;
   int mismatches;
   int compares;
   int rr_cnt = 0;
   int rr_base;
   int n;

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   ciwt_host u_host (.clock(clock), .stb(stb), .wdata(wdata));

   ciwt_timer #(.OPTIONS(CIWT_PRESET_FULL),
      .DEFAULT_PERIOD(32'h0000_000f)) u_dut (
      .clock(clock), .rstn(rstn), .period_lo_wr(stb[0]),
      .period_hi_wr(stb[1]), .period_wdata(wdata), .snap_req(stb[4]),
      .ctrl_wr(stb[2]), .ctrl_wdata(wdata[3:0]), .status_wr(stb[3]),
      .status_wdata(wdata), .period_q(f_pq), .snap_q(f_sq),
      .expired_flag(f_exp), .running(f_run), .irq_enable_bit(f_ie),
      .repeat_mode_bit(f_rm), .irq(f_irq), .timeout_pulse(f_tp),
      .reset_request(f_rr));

   // Shares every strobe with the full build
   ciwt_timer #(.OPTIONS(CIWT_PRESET_WATCHDOG),
      .DEFAULT_PERIOD(32'h0000_000f)) u_wdg (
      .clock(clock), .rstn(rstn), .period_lo_wr(stb[0]),
      .period_hi_wr(stb[1]), .period_wdata(wdata), .snap_req(stb[4]),
      .ctrl_wr(stb[2]), .ctrl_wdata(wdata[3:0]), .status_wr(stb[3]),
      .status_wdata(wdata), .period_q(w_pq), .snap_q(w_sq),
      .expired_flag(w_exp), .running(w_run), .irq_enable_bit(w_ie),
      .repeat_mode_bit(w_rm), .irq(w_irq), .timeout_pulse(w_tp),
      .reset_request(w_rr));

   // Simple preset: fixed period, never halts, maskable interrupt
   ciwt_timer #(.OPTIONS(CIWT_PRESET_SIMPLE),
      .DEFAULT_PERIOD(32'h0000_000f)) u_smp (
      .clock(clock), .rstn(rstn), .period_lo_wr(stb[0]),
      .period_hi_wr(stb[1]), .period_wdata(wdata), .snap_req(stb[4]),
      .ctrl_wr(stb[2]), .ctrl_wdata(wdata[3:0]), .status_wr(stb[3]),
      .status_wdata(wdata), .period_q(s_pq), .snap_q(),
      .expired_flag(), .running(s_run), .irq_enable_bit(),
      .repeat_mode_bit(), .irq(s_irq), .timeout_pulse(),
      .reset_request());

   always @(posedge clock) begin
      if (w_rr === 1'b1) begin
         rr_cnt <= rr_cnt + 1;
      end
   end

   task automatic give_verdict();
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input ciwt_word_t seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Negedges until the chosen pulse is seen; w picks the watchdog
   task automatic wait_hi(input bit w, output int cnt);
      for (cnt = 1; cnt <= 200; cnt++) begin
         @(negedge clock);
         if ((w ? w_rr : f_tp) === 1'b1) begin
            break;
         end
      end
      if (cnt > 200) begin
         mismatches++;
         give_verdict();
      end
   endtask

   initial begin
      rstn = 1'b0;
      mismatches = 0;
      compares = 0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      chk("f_run", f_run, 0);
      chk("w_run", w_run, 0);
      chk("s_run", s_run, 1);
      chk("f_pq", f_pq, 32'h0000_000f);
      chk("f_exp", f_exp, 0);
      u_host.put(5'h01, 16'h0009);
      u_host.put(5'h02, 16'h0000);
      u_host.put(5'h10, 16'h0000);
      @(negedge clock);
      chk("f_pq", f_pq, 32'h0000_0009);
      chk("w_pq", w_pq, 32'h0000_000f);
      chk("f_sq", f_sq, 32'h0000_0009);
      chk("w_sq", w_sq, 0);
      chk("s_pq", s_pq, 32'h0000_000f);
      u_host.put(5'h04, 16'h0007);
      @(negedge clock);
      chk("f_run", f_run, 1);
      chk("w_run", w_run, 1);
      chk("f_ie", f_ie, 1);
      chk("f_rm", f_rm, 1);
      wait_hi(0, n);
      wait_hi(0, n);
      chk("f_gap", n, 10);
      chk("f_exp", f_exp, 1);
      chk("f_irq", f_irq, 1);
      chk("f_rr", f_rr, 0);
      @(negedge clock);
      chk("f_tp", f_tp, 0);
      wait_hi(1, n);
      wait_hi(1, n);
      chk("w_gap", n, 16);
      chk("w_exp", w_exp, 1);
      chk("w_tp", w_tp, 0);
      chk("w_irq", w_irq, 1);
      chk("w_rm", w_rm, 1);
      chk("s_irq", s_irq, 1);
      // Step off the full build's zero cycle, where the set would win
      @(negedge clock);
      u_host.put(5'h08, 16'h0000);
      @(negedge clock);
      chk("f_exp", f_exp, 0);
      chk("f_irq", f_irq, 0);
      // Masked interrupt: flag sets, request stays low
      u_host.put(5'h04, 16'h0002);
      wait_hi(0, n);
      chk("f_exp", f_exp, 1);
      chk("f_irq", f_irq, 0);
      chk("s_irq", s_irq, 0);
      u_host.put(5'h04, 16'h0008);
      @(negedge clock);
      chk("f_run", f_run, 0);
      chk("w_run", w_run, 1);
      chk("s_run", s_run, 1);
      u_host.kick();
      rr_base = rr_cnt;
      repeat (6) u_host.kick();
      u_host.put(5'h01, 16'h0005);
      // Gaps are counted from a falling edge
      @(negedge clock);
      chk("rr_cnt", rr_cnt - rr_base, 0);
      wait_hi(1, n);
      chk("w_kick", n, 16);
      // Single-shot: one zero, then halted
      u_host.put(5'h04, 16'h0004);
      @(negedge clock);
      wait_hi(0, n);
      chk("f_once", n, 6);
      @(negedge clock);
      chk("f_run", f_run, 0);
      give_verdict();
   end
endmodule
